// ### rps_sequencer.sv
// file: recording packet sequencer top
// Overview of operation
// - recording opens with format 1 setup packets
// - time packet is first dynamic packet
// - data packets between first time and index
// - root index last when index enabled
// - data packet spans at most 100 ms
// - flush within 100 ms, never empty packets
// - commit within 1000 ms of header time
// - time packets at least once per second
// - source none still sends one time packet
`timescale 1ns/1ps
`default_nettype none
module rps_sequencer
   import rps_pkg::*;
#(
   parameter int unsigned FIFO_D = FIFO_DEPTH,
   parameter int unsigned FLUSH_T = FLUSH_TICKS,
   parameter int unsigned COMMIT_T = COMMIT_TICKS,
   parameter int unsigned TIME_T = TIME_TICKS,
   parameter int unsigned MAX_WORDS = 256
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // recording control
   input wire logic i_start,
   input wire logic i_stop,
   input wire logic i_index_en,
   input wire logic i_time_none,
   // setup record words
   input wire logic i_setup_valid,
   input wire logic i_setup_last,
   input wire logic [DATA_W-1:0] i_setup_data,
   output logic o_setup_ready,
   // time words from the time source
   input wire logic [DATA_W-1:0] i_time_data,
   // channel data
   input wire logic i_ch_valid,
   input wire logic [DATA_W-1:0] i_ch_data,
   output logic o_ch_ready,
   // packet stream to media
   output logic o_pkt_valid,
   output rps_word_t o_pkt,
   input wire logic i_pkt_ready,
   // status
   output logic o_busy,
   output logic [RTC_W-1:0] o_rtc
);
   initial
   begin
      if (FLUSH_T == 0 || FLUSH_T >= COMMIT_T || MAX_WORDS < 2)
         $error("rps_sequencer: bad deadline or packet size parameters");
      if (MAX_WORDS > 65536)
         $error("rps_sequencer: packet size exceeds the word counter");
      if (RTC_DIV < 1 || RTC_DIV > 16)
         $error("rps_sequencer: clock ratio exceeds the tick divider");
   end

   typedef struct packed {
      rps_state_t st;
      logic [3:0] div;
      logic [RTC_W-1:0] rtc;
      logic open;
      logic [RTC_W-1:0] first_rtc;
      logic [15:0] words;
      logic [RTC_W-1:0] last_time;
      logic stop_pend;
      logic sop;
      logic wr_valid;
      rps_word_t wr;
   } rps_st_t;

   rps_st_t s_q, s_d;
   logic fifo_ready;
   logic [$bits(rps_word_t)-1:0] fifo_out;
   logic [RTC_W-1:0] age, time_age;
   logic flush_due, time_due;

   rps_fifo #(.WIDTH($bits(rps_word_t)), .DEPTH(FIFO_D)) u_fifo (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_valid(s_q.wr_valid),
      .i_data(s_q.wr),
      .o_ready(fifo_ready),
      .o_valid(o_pkt_valid),
      .o_data(fifo_out),
      .i_ready(i_pkt_ready)
   );
   assign o_pkt = rps_word_t'(fifo_out);

   // ages are differences, so a wrapping counter does no harm
   assign age = s_q.rtc - s_q.first_rtc;
   assign time_age = s_q.rtc - s_q.last_time;
   // close early leaves margin for fifo drain inside the commit deadline
   assign flush_due = s_q.open && (age >= RTC_W'(FLUSH_T - 1));
   assign time_due = !i_time_none && (time_age >= RTC_W'(TIME_T - 1));

   // a staged word is only replaced once the fifo took it
   logic can_wr;
   assign can_wr = !s_q.wr_valid || fifo_ready;
   assign o_setup_ready = (s_q.st == ST_SETUP) && can_wr;
   // refusing data while a close is due keeps the marker ahead of new words
   assign o_ch_ready = (s_q.st == ST_RUN) && can_wr && !flush_due && !time_due
      && !s_q.stop_pend;
   assign o_busy = s_q.st != ST_IDLE;
   assign o_rtc = s_q.rtc;

   always_comb
   begin
      s_d = s_q;
      if (can_wr)
         s_d.wr_valid = 1'b0;
      // 10 MHz relative time counter from an enable divider
      // it runs while idle too, so header times never step back between recordings
      if (s_q.div == 4'(RTC_DIV - 1))
      begin
         s_d.div = '0;
         s_d.rtc = s_q.rtc + 1'b1;
      end
      else
         s_d.div = s_q.div + 1'b1;
      if (i_stop && s_q.st != ST_IDLE)
         s_d.stop_pend = 1'b1;
      case (s_q.st)
         ST_IDLE:
         begin
            // a stop seen while idle has nothing to end
            s_d.stop_pend = 1'b0;
            if (i_start)
            begin
               s_d.st = ST_SETUP;
               s_d.sop = 1'b1;
            end
         end
         ST_SETUP:
            if (i_setup_valid && can_wr)
            begin
               s_d.wr = '{KIND_SETUP, s_q.sop, i_setup_last, s_q.rtc, i_setup_data};
               s_d.wr_valid = 1'b1;
               s_d.sop = 1'b0;
               if (i_setup_last)
                  s_d.st = ST_TIME0;
            end
         ST_TIME0:
            if (can_wr)
            begin
               // sent even with no time source so the recording has a time base
               s_d.wr = '{KIND_TIME, 1'b1, 1'b1, s_q.rtc, i_time_data};
               s_d.wr_valid = 1'b1;
               s_d.last_time = s_q.rtc;
               s_d.st = ST_RUN;
            end
         ST_RUN:
            if (can_wr)
            begin
               // a due time packet closes the open one first, so packets never nest
               if (flush_due || ((s_q.stop_pend || time_due) && s_q.open))
               begin
                  // close on a marker word; no packet is ever opened without data
                  s_d.wr = '{KIND_DATA, 1'b0, 1'b1, s_q.first_rtc, '0};
                  s_d.wr_valid = 1'b1;
                  s_d.open = 1'b0;
               end
               else if (time_due)
               begin
                  s_d.wr = '{KIND_TIME, 1'b1, 1'b1, s_q.rtc, i_time_data};
                  s_d.wr_valid = 1'b1;
                  s_d.last_time = s_q.rtc;
               end
               else if (s_q.stop_pend)
                  s_d.st = i_index_en ? ST_INDEX : ST_DONE;
               else if (i_ch_valid)
               begin
                  s_d.wr = '{KIND_DATA, !s_q.open, 1'b0,
                     s_q.open ? s_q.first_rtc : s_q.rtc, i_ch_data};
                  s_d.wr_valid = 1'b1;
                  if (!s_q.open)
                  begin
                     s_d.open = 1'b1;
                     s_d.first_rtc = s_q.rtc;
                     s_d.words = 16'h0001;
                  end
                  else
                     s_d.words = s_q.words + 1'b1;
                  // the size limit closes on the data word itself, no marker needed
                  if (s_q.open && s_q.words == 16'(MAX_WORDS - 1))
                  begin
                     s_d.wr.eop = 1'b1;
                     s_d.open = 1'b0;
                  end
               end
            end
         ST_INDEX:
            if (can_wr)
            begin
               s_d.wr = '{KIND_INDEX, 1'b1, 1'b1, s_q.rtc, '0};
               s_d.wr_valid = 1'b1;
               s_d.st = ST_DONE;
            end
         ST_DONE:
            // stay busy until the last staged word has reached the fifo
            if (can_wr)
               s_d.st = ST_IDLE;
         default:
            s_d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
      end
      else
         s_q <= s_d;
   end
endmodule : rps_sequencer
`default_nettype wire

// ### rps_pkg.sv
// package: shared types and constants for the recording packet sequencer
package rps_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned RTC_HZ = 10_000_000;
   localparam int unsigned RTC_DIV = CLK_HZ / RTC_HZ;
   localparam int unsigned FLUSH_MS = 100;
   localparam int unsigned COMMIT_MS = 1000;
   localparam int unsigned TIME_PERIOD_MS = 1000;
   // deadlines expressed in relative time counter ticks
   localparam int unsigned FLUSH_TICKS = FLUSH_MS * (RTC_HZ / 1000);
   localparam int unsigned COMMIT_TICKS = COMMIT_MS * (RTC_HZ / 1000);
   localparam int unsigned TIME_TICKS = TIME_PERIOD_MS * (RTC_HZ / 1000);
   localparam int unsigned RTC_W = 48;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam logic [3:0] KIND_SETUP = 4'h1;
   localparam logic [3:0] KIND_TIME = 4'h2;
   localparam logic [3:0] KIND_DATA = 4'h3;
   localparam logic [3:0] KIND_INDEX = 4'h4;

   typedef enum {ST_IDLE, ST_SETUP, ST_TIME0, ST_RUN, ST_INDEX, ST_DONE} rps_state_t;

   // one word of the outgoing packet stream
   typedef struct packed {
      logic [3:0] kind;
      logic sop;
      logic eop;
      logic [RTC_W-1:0] rtc;
      logic [DATA_W-1:0] data;
   } rps_word_t;
endpackage : rps_pkg

// ### rps_fifo.sv
// file: parameterised valid/ready fifo
`timescale 1ns/1ps
`default_nettype none
module rps_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 32
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // fill side
   input wire logic i_valid,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_ready,
   // drain side
   output logic o_valid,
   output logic [WIDTH-1:0] o_data,
   input wire logic i_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("rps_fifo depth must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } rps_fifo_st_t;

   logic [WIDTH-1:0] mem [DEPTH];
   rps_fifo_st_t s_q, s_d;
   logic full, empty, push, pop;

   assign full = (s_q.wr[AW] != s_q.rd[AW]) && (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]);
   assign empty = s_q.wr == s_q.rd;
   assign o_ready = !full;
   assign o_valid = !empty;
   assign o_data = mem[s_q.rd[AW-1:0]];
   assign push = i_valid && !full;
   assign pop = i_ready && !empty;

   always_comb
   begin
      s_d = s_q;
      if (push)
         s_d.wr = s_q.wr + 1'b1;
      if (pop)
         s_d.rd = s_q.rd + 1'b1;
   end

   always_ff @(posedge i_clk)
   begin
      if (push)
         mem[s_q.wr[AW-1:0]] <= i_data;
      if (i_rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end
endmodule : rps_fifo
`default_nettype wire

// ### rps_media.sv
// model: media sink that accepts words promptly or only one cycle in four
`timescale 1ns/1ps
`default_nettype none
module rps_media (
   // clock and mode
   input wire logic i_clk,
   input wire logic i_slow,
   // acceptance
   output logic o_ready
);
   logic [1:0] ph_q = 2'h0;
   always_ff @(posedge i_clk)
      ph_q <= ph_q + 2'h1;
   // a slow store still never refuses for ever, so deadlines stay reachable
   assign o_ready = !i_slow || (ph_q == 2'h0);
endmodule : rps_media
`default_nettype wire

// ### rps_sequencer_sva.sv
// checker: stream order and timing of the packet sequencer
`timescale 1ns/1ps
`default_nettype none
module rps_sequencer_chk
   import rps_pkg::*;
#(
   parameter int unsigned COMMIT_T = COMMIT_TICKS,
   parameter int unsigned TIME_T = TIME_TICKS
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic i_index_en,
   input wire logic i_time_none,
   input wire logic o_busy,
   input wire logic o_pkt_valid,
   input wire rps_word_t o_pkt,
   input wire logic i_pkt_ready,
   input wire logic [RTC_W-1:0] o_rtc
);
   logic acc;
   logic dat;
   logic tim_q;
   logic end_q;
   logic [RTC_W-1:0] hd_q;
   logic [31:0] gap_q;
   assign acc = o_pkt_valid && i_pkt_ready;
   assign dat = acc && (o_pkt.kind == KIND_DATA);
   always_ff @(posedge i_clk)
   begin
      if (i_rst || (i_start && !o_busy))
      begin
         tim_q <= 1'b0;
         end_q <= 1'b0;
      end
      else
      begin
         tim_q <= tim_q || (acc && (o_pkt.kind == KIND_TIME));
         end_q <= end_q || (acc && (o_pkt.kind == KIND_INDEX) && o_pkt.eop);
      end
      hd_q <= (dat && o_pkt.sop) ? o_pkt.rtc : hd_q;
      // time packets may queue behind one open data packet, hence the double period
      gap_q <= ((acc && (o_pkt.kind == KIND_TIME)) || !o_busy) ? 32'h0 : gap_q + 32'h1;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   setup_first_a: assert property (acc && (o_pkt.kind == KIND_SETUP) |-> !tim_q)
      else $error("setup word after time packet");
   time_first_a: assert property (dat |-> tim_q)
      else $error("data word before first time packet");
   index_last_a: assert property (acc |-> !end_q)
      else $error("word after index packet");
   index_en_a: assert property (acc && (o_pkt.kind == KIND_INDEX) |-> i_index_en)
      else $error("index packet while disabled");
   no_empty_a: assert property (dat && o_pkt.sop |-> !o_pkt.eop)
      else $error("empty data packet");
   head_rtc_a: assert property (dat && !o_pkt.sop |-> o_pkt.rtc == hd_q)
      else $error("data word counter differs from head");
   commit_due_a: assert property (dat |-> (o_rtc - o_pkt.rtc) <= COMMIT_T)
      else $error("data word committed late");
   time_rate_a: assert property (o_busy && !i_time_none |-> gap_q <= 2 * TIME_T * RTC_DIV)
      else $error("time packets too far apart");
   rtc_pace_a: assert property ($changed(o_rtc) |=> $stable(o_rtc) [*8])
      else $error("relative counter runs too fast");
endmodule : rps_sequencer_chk
bind rps_sequencer rps_sequencer_chk #(.COMMIT_T(COMMIT_T), .TIME_T(TIME_T)) chk_inst (
   .i_clk(i_clk), .i_rst(i_rst), .i_start(i_start), .i_index_en(i_index_en),
   .i_time_none(i_time_none), .o_busy(o_busy), .o_pkt_valid(o_pkt_valid),
   .o_pkt(o_pkt), .i_pkt_ready(i_pkt_ready), .o_rtc(o_rtc));
`default_nettype wire

// ### tb_recording_packet_sequencer.sv
// testbench: recordings with and without index and periodic time
`timescale 1ns/1ps
`default_nettype none
module tb_recording_packet_sequencer
   import rps_pkg::*;
;
   localparam int TT = 200;
   localparam int MW = 4;
   logic i_clk = 0, i_rst = 1, i_start = 0, i_stop = 0, i_index_en = 0, i_time_none = 0;
   logic i_setup_valid = 0, i_setup_last = 0, i_ch_valid = 0, slow = 0;
   logic [DATA_W-1:0] i_setup_data = 0, i_ch_data = 0;
   logic o_setup_ready, o_ch_ready, o_pkt_valid, rdy, o_busy;
   logic [RTC_W-1:0] o_rtc;
   rps_word_t o_pkt;
   rps_word_t q[$];
   int error_cnt = 0, num_checks = 0, cyc = 0;
   always #5 i_clk = ~i_clk;
   rps_sequencer #(.FLUSH_T(50), .COMMIT_T(500), .TIME_T(TT), .MAX_WORDS(MW))
      rps_sequencer_inst (
      .i_clk(i_clk), .i_rst(i_rst), .i_start(i_start), .i_stop(i_stop),
      .i_index_en(i_index_en), .i_time_none(i_time_none), .i_setup_valid(i_setup_valid),
      .i_setup_last(i_setup_last), .i_setup_data(i_setup_data), .o_setup_ready(o_setup_ready),
      .i_time_data(32'h7100_0000), .i_ch_valid(i_ch_valid), .i_ch_data(i_ch_data),
      .o_ch_ready(o_ch_ready), .o_pkt_valid(o_pkt_valid), .o_pkt(o_pkt),
      .i_pkt_ready(rdy), .o_busy(o_busy), .o_rtc(o_rtc));
   rps_media rps_media_inst (.i_clk(i_clk), .i_slow(slow), .o_ready(rdy));
   task give_verdict;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict
   always @(posedge i_clk)
   begin
      cyc++;
      if (o_pkt_valid === 1'b1 && rdy === 1'b1)
         q.push_back(o_pkt);
      if (cyc == 40000)
      begin
         error_cnt++;
         give_verdict();
      end
   end
   task chk(input string n, input logic [63:0] e, input logic [63:0] g);
      num_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // one word on the setup or channel port; held until taken
   task put(input logic s, input logic [31:0] d, input logic l);
      i_setup_valid <= s;
      i_ch_valid <= !s;
      i_setup_data <= d;
      i_ch_data <= d;
      i_setup_last <= l;
      do @(negedge i_clk); while ((s ? o_setup_ready : o_ch_ready) !== 1'b1);
      @(posedge i_clk);
      i_setup_valid <= 0;
      i_ch_valid <= 0;
      @(posedge i_clk);
   endtask : put
   // the quiet gap lets the open packet time out and periodic time packets fall due
   task run_rec(input logic ix, input logic tn, input int nw);
      q.delete();
      i_index_en <= ix;
      i_time_none <= tn;
      i_start <= 1;
      @(posedge i_clk);
      i_start <= 0;
      put(1, 32'h5e70_0001, 0);
      put(1, 32'h5e70_0002, 1);
      put(0, 32'hda7a_0001, 0);
      for (int k = 2; k <= nw; k++)
         put(0, 32'hda7a_0000 + k, 0);
      repeat (3 * TT * RTC_DIV) @(posedge i_clk);
      put(0, 32'hda7a_0002, 0);
      i_stop <= 1;
      @(posedge i_clk);
      i_stop <= 0;
      for (int n = 0; n < 5000 && (o_busy !== 1'b0 || o_pkt_valid !== 1'b0); n++)
         @(negedge i_clk);
      chk("recording end", 0, {o_busy, o_pkt_valid});
      // the next request starts on a rising edge
      @(posedge i_clk);
   endtask : run_rec
   function automatic int times();
      int c = 0;
      foreach (q[i]) c += (q[i].kind == KIND_TIME && q[i].sop);
      return c;
   endfunction : times
   task check_marker;
      int j = 0;
      foreach (q[i]) if (q[i].kind == KIND_DATA && q[i].data == 32'hda7a_0001) j = i;
      chk("flush eop", 1, q[j+1].eop);
      chk("flush data", 0, q[j+1].data);
   endtask : check_marker
   task t_index_periodic;
      slow <= 0;
      run_rec(1, 0, 1);
      chk("first kind", KIND_SETUP, q[0].kind);
      chk("setup sop", 1, q[0].sop);
      chk("setup tail", {1'b1, 32'h5e70_0002}, {q[1].eop, q[1].data});
      chk("second kind", KIND_TIME, q[2].kind);
      chk("time data", 32'h7100_0000, q[2].data);
      chk("periodic time", 1, times() >= 3);
      chk("last kind", KIND_INDEX, q[q.size()-1].kind);
      check_marker();
   endtask : t_index_periodic
   task t_none_slow;
      slow <= 1;
      run_rec(0, 1, 1);
      chk("time first", KIND_TIME, q[2].kind);
      chk("single time", 1, times());
      chk("no index", KIND_DATA, q[q.size()-1].kind);
      check_marker();
   endtask : t_none_slow
   // words one idle cycle apart reach the size limit, which closes without a marker
   task t_size_limit;
      int j;
      j = 0;
      slow <= 0;
      run_rec(0, 0, MW + 1);
      foreach (q[i]) if (q[i].kind == KIND_DATA && q[i].data == 32'hda7a_0000 + MW) j = i;
      chk("size eop", 1, q[j].eop);
      chk("next sop", {1'b1, 32'hda7a_0000 + MW + 1}, {q[j+1].sop, q[j+1].data});
   endtask : t_size_limit
   initial
   begin
      repeat (16) @(posedge i_clk);
      i_rst <= 0;
      @(posedge i_clk);
      chk("rtc reset", 0, o_rtc[31:0]);
      t_index_periodic();
      t_none_slow();
      t_size_limit();
      give_verdict();
   end
endmodule : tb_recording_packet_sequencer
`default_nettype wire
